// ### hdl/osf_regs.svh
// register offsets, field positions, reset values and timing counts of the sample buffer block
`ifndef OSF_REGS_SVH
`define OSF_REGS_SVH

`define OSF_ADDR_WR_POS 8'h04
`define OSF_ADDR_LOST 8'h05
`define OSF_ADDR_RD_POS 8'h06
`define OSF_ADDR_DATA 8'h07
`define OSF_ADDR_BUF_CFG 8'h08
`define OSF_ADDR_MODE 8'h09
`define OSF_ADDR_ACQ_CFG 8'h0A
`define OSF_ADDR_LAST 8'hFF

`define OSF_BUF_CFG_RESET 8'h00
`define OSF_MODE_RESET 8'h00
`define OSF_ACQ_CFG_RESET 8'h00

`define OSF_AVG_MSB 7
`define OSF_AVG_LSB 5
`define OSF_WRAP_BIT 4
`define OSF_AFULL_MSB 3
`define OSF_AFULL_LSB 0
`define OSF_PSAVE_BIT 7
`define OSF_SRST_BIT 6
`define OSF_MODE_MSB 2
`define OSF_MODE_LSB 0
`define OSF_RANGE_MSB 6
`define OSF_RANGE_LSB 5
`define OSF_RATE_MSB 4
`define OSF_RATE_LSB 2
`define OSF_PW_MSB 1
`define OSF_PW_LSB 0

`define OSF_MODE_HR 3'h2
`define OSF_MODE_DUAL 3'h3
`define OSF_MODE_MULTI 3'h7

`define OSF_DEPTH 32
`define OSF_LOST_MAX 5'h0F
`define OSF_SRST_CYCLES 4
`define OSF_RATE_MAX_BY_PW 12'hBBF

`endif

// ### hdl/osf_pkg.sv
// types shared by the sample buffer block
package osf_pkg;
   typedef enum logic {OSF_RUN, OSF_SRST} osf_state_e;
   typedef logic [17:0] osf_sample_t;
   typedef logic [4:0] osf_ptr_t;
endpackage

// ### hdl/osf_avg.sv
// per-channel averaging and decimation of converter samples
`timescale 1ns/100ps
module osf_avg #(
   parameter int W = 18,
   parameter int MAXSHIFT = 5
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   input wire logic [2:0] shiftCode,
   output logic outValid,
   output logic [W-1:0] outData
);
   logic [W+MAXSHIFT-1:0] sum_q, sum_d;
   logic [MAXSHIFT-1:0] cnt_q, cnt_d;
   logic outValid_q, outValid_d;
   logic [W-1:0] outData_q, outData_d;

   initial begin
      if (W < 1 || MAXSHIFT < 1 || MAXSHIFT > 7) begin
         $error("osf_avg: unsupported width or shift");
      end
   end

   always_comb begin
      logic [W+MAXSHIFT-1:0] total;
      logic [MAXSHIFT-1:0] last;
      total = sum_q + (W+MAXSHIFT)'(inData);
      last = MAXSHIFT'((32'd1 << shiftCode) - 32'd1);
      sum_d = sum_q;
      cnt_d = cnt_q;
      outValid_d = 1'b0;
      outData_d = outData_q;
      if (clear) begin
         sum_d = '0;
         cnt_d = '0;
      end else if (inValid) begin
         // decimate: one output per 2^shift inputs
         if (cnt_q == last) begin
            outData_d = W'(total >> shiftCode);
            outValid_d = 1'b1;
            sum_d = '0;
            cnt_d = '0;
         end else begin
            sum_d = total;
            cnt_d = cnt_q + MAXSHIFT'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sum_q <= '0;
         cnt_q <= '0;
         outValid_q <= 1'b0;
         outData_q <= '0;
      end else begin
         sum_q <= sum_d;
         cnt_q <= cnt_d;
         outValid_q <= outValid_d;
         outData_q <= outData_d;
      end
   end

   assign outValid = outValid_q;
   assign outData = outData_q;
endmodule

// ### hdl/osf_ctrl.sv
// sample buffer, acquisition control and register map of the optical sensor
`timescale 1ns/100ps
`include "osf_regs.svh"
// Notes on behaviour
// - write position advances once per stored sample
// - read position advances once per popped sample
// - power-on reset zeroes both positions
// - three bytes per channel, high bits first
// - averaging field selects 1 to 32 samples
// - wrap bit chooses overwrite or hold when full
// - almost-full flag at 32 minus field unread
// - power-save keeps registers, forces flags low
// - soft reset restores defaults, bit self-clears
// - soft reset raises no power-ready event
// - mode field selects red or red plus IR
// - mode change keeps settings and stored data
// - range field selects converter full scale
// - rate field selects 50 to 3200 sps
// - too-high rate clamped to width's maximum
// - pulse width field sets width and resolution
// - circular buffer of 32 sample entries
// - losses counted, saturate at 15, cleared on pop
// - data register reads keep the address pointer
// - stored values left-justified at bit 17
module osf_ctrl #(
   parameter int CLK_HZ = 50000000,
   parameter logic [11:0] RATE_MAX_BY_PW = `OSF_RATE_MAX_BY_PW
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic regAddrLoad,
   input wire logic [7:0] regAddr,
   input wire logic regWrStb,
   input wire logic [7:0] regWrData,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   output logic sampleTick,
   input wire logic sampleValid,
   input wire logic [17:0] redSample,
   input wire logic [17:0] irSample,
   output logic [1:0] converterRangeSelect,
   output logic [2:0] sampleRateSelect,
   output logic [1:0] ledPulseWidthSelect,
   output logic powerSaveActive,
   output logic almostFullFlag,
   output logic powerReadyFlag,
   input wire logic powerReadyClear
);
   localparam int DEPTH = `OSF_DEPTH;

   initial begin
      if (CLK_HZ < 3200 || CLK_HZ / 50 >= (1 << 24)) begin
         $error("osf_ctrl: clock rate out of range");
      end
   end

   function automatic logic [2:0] rateMax(input logic [1:0] pw);
      rateMax = RATE_MAX_BY_PW[pw*3 +: 3];
   endfunction

   function automatic logic [23:0] ratePeriod(input logic [2:0] code);
      int sps;
      unique case (code)
         3'h0: sps = 50;
         3'h1: sps = 100;
         3'h2: sps = 200;
         3'h3: sps = 400;
         3'h4: sps = 800;
         3'h5: sps = 1000;
         3'h6: sps = 1600;
         3'h7: sps = 3200;
      endcase
      ratePeriod = 24'(CLK_HZ / sps);
   endfunction

   function automatic logic modeValid(input logic [2:0] m);
      modeValid = (m == `OSF_MODE_HR) || (m == `OSF_MODE_DUAL) || (m == `OSF_MODE_MULTI);
   endfunction

   osf_pkg::osf_state_e state_q, state_d;
   logic [2:0] srstCnt_q, srstCnt_d;
   osf_pkg::osf_sample_t mem_q [DEPTH][2];
   osf_pkg::osf_sample_t mem_d [DEPTH][2];
   osf_pkg::osf_ptr_t wr_q, wr_d, rd_q, rd_d, latch_q, latch_d;
   logic full_q, full_d;
   logic [4:0] lost_q, lost_d;
   logic [2:0] byteIdx_q, byteIdx_d;
   logic [7:0] addr_q, addr_d, bufCfg_q, bufCfg_d, acqCfg_q, acqCfg_d, rdData_q, rdData_d;
   logic psave_q, psave_d;
   logic [2:0] mode_q, mode_d;
   logic [23:0] divCnt_q, divCnt_d;
   logic tick_q, tick_d, afull_q, afull_d, pwrRdy_q, pwrRdy_d, porSeen_q;
   logic avgValid, avgClear, running;
   osf_pkg::osf_sample_t redAvg, irAvg;
   logic [2:0] avgShift;

   // averaging codes above 100 all select 32 samples
   assign avgShift = (bufCfg_q[`OSF_AVG_MSB:`OSF_AVG_LSB] > 3'h4) ? 3'h5 : bufCfg_q[`OSF_AVG_MSB:`OSF_AVG_LSB];
   assign running = modeValid(mode_q) && !psave_q && (state_q == osf_pkg::OSF_RUN);
   assign avgClear = !running;

   osf_avg #(.W(18), .MAXSHIFT(5)) u_avgRed (
      .clock(clock), .arst_n(arst_n), .clear(avgClear), .inValid(sampleValid && running),
      .inData(redSample), .shiftCode(avgShift), .outValid(avgValid), .outData(redAvg)
   );
   osf_avg #(.W(18), .MAXSHIFT(5)) u_avgIr (
      .clock(clock), .arst_n(arst_n), .clear(avgClear), .inValid(sampleValid && running),
      .inData(irSample), .shiftCode(avgShift), .outValid(), .outData(irAvg)
   );

   always_comb begin
      osf_pkg::osf_ptr_t sel;
      logic [1:0] pw, ch;
      logic [2:0] lastByte;
      logic [5:0] unread;
      logic [17:0] word, mask;
      logic empty, dual;
      sel = '0;
      ch = '0;
      word = '0;
      unread = '0;
      empty = !full_q && (wr_q == rd_q);
      pw = acqCfg_q[`OSF_PW_MSB:`OSF_PW_LSB];
      dual = (mode_q != `OSF_MODE_HR);
      lastByte = dual ? 3'h5 : 3'h2;
      // bits below the selected resolution read zero; data stays left-justified
      mask = 18'h3FFFF << (2'h3 - pw);
      state_d = state_q;
      srstCnt_d = srstCnt_q;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      latch_d = latch_q;
      full_d = full_q;
      lost_d = lost_q;
      byteIdx_d = byteIdx_q;
      addr_d = addr_q;
      bufCfg_d = bufCfg_q;
      acqCfg_d = acqCfg_q;
      rdData_d = rdData_q;
      psave_d = psave_q;
      mode_d = mode_q;
      if (regAddrLoad) begin
         addr_d = regAddr;
         byteIdx_d = '0;
      end else if (regRdStb) begin
         if (addr_q == `OSF_ADDR_DATA) begin
            sel = (byteIdx_q == 3'h0) ? rd_q : latch_q;
            ch = (byteIdx_q > 3'h2) ? 2'h1 : 2'h0;
            word = mem_q[sel][ch[0]];
            // byte order: bits 17:16, then 15:8, then 7:0
            unique case (byteIdx_q - (ch[0] ? 3'h3 : 3'h0))
               3'h0: rdData_d = {6'h00, word[17:16]};
               3'h1: rdData_d = word[15:8];
               default: rdData_d = word[7:0];
            endcase
            if (byteIdx_q == 3'h0) begin
               latch_d = rd_q;
               if (!empty) begin
                  rd_d = rd_q + 5'h01;
                  full_d = 1'b0;
                  lost_d = '0;
               end
            end
            byteIdx_d = (byteIdx_q >= lastByte) ? 3'h0 : byteIdx_q + 3'h1;
            // address pointer holds on the data register
         end else begin
            unique case (addr_q)
               `OSF_ADDR_WR_POS: rdData_d = {3'h0, wr_q};
               `OSF_ADDR_LOST: rdData_d = {3'h0, lost_q};
               `OSF_ADDR_RD_POS: rdData_d = {3'h0, rd_q};
               `OSF_ADDR_BUF_CFG: rdData_d = bufCfg_q;
               `OSF_ADDR_MODE: rdData_d = {psave_q, state_q == osf_pkg::OSF_SRST, 3'h0, mode_q};
               `OSF_ADDR_ACQ_CFG: rdData_d = {1'b0, acqCfg_q[6:0]};
               default: rdData_d = 8'h00;
            endcase
            if (addr_q != `OSF_ADDR_LAST) begin
               addr_d = addr_q + 8'h01;
            end
         end
      end else if (regWrStb) begin
         unique case (addr_q)
            `OSF_ADDR_WR_POS: begin
               if (modeValid(mode_q)) begin
                  wr_d = regWrData[4:0];
                  full_d = 1'b0;
                  byteIdx_d = '0;
               end
            end
            `OSF_ADDR_LOST: lost_d = regWrData[4:0];
            `OSF_ADDR_RD_POS: begin
               rd_d = regWrData[4:0];
               full_d = 1'b0;
               byteIdx_d = '0;
            end
            `OSF_ADDR_BUF_CFG: bufCfg_d = regWrData;
            `OSF_ADDR_MODE: begin
               psave_d = regWrData[`OSF_PSAVE_BIT];
               mode_d = regWrData[`OSF_MODE_MSB:`OSF_MODE_LSB];
               if (regWrData[`OSF_SRST_BIT]) begin
                  state_d = osf_pkg::OSF_SRST;
                  srstCnt_d = 3'(`OSF_SRST_CYCLES - 1);
               end
            end
            `OSF_ADDR_ACQ_CFG: begin
               acqCfg_d = {1'b0, regWrData[6:0]};
               // rate beyond what the pulse width allows is replaced by the maximum
               if (regWrData[`OSF_RATE_MSB:`OSF_RATE_LSB] > rateMax(regWrData[`OSF_PW_MSB:`OSF_PW_LSB])) begin
                  acqCfg_d[`OSF_RATE_MSB:`OSF_RATE_LSB] = rateMax(regWrData[`OSF_PW_MSB:`OSF_PW_LSB]);
               end
            end
            default: ;
         endcase
         if (addr_q != `OSF_ADDR_LAST) begin
            addr_d = addr_q + 8'h01;
         end
      end
      if (avgValid && running) begin
         if (full_d) begin
            lost_d = (lost_d >= `OSF_LOST_MAX) ? `OSF_LOST_MAX : lost_d + 5'h01;
         end
         if (!full_d || bufCfg_q[`OSF_WRAP_BIT]) begin
            mem_d[wr_d][0] = redAvg & mask;
            mem_d[wr_d][1] = dual ? (irAvg & mask) : 18'h00000;
            if (full_d) begin
               rd_d = rd_d + 5'h01;
            end
            full_d = (wr_d + 5'h01) == rd_d;
            wr_d = wr_d + 5'h01;
         end
      end
      if (state_q == osf_pkg::OSF_SRST) begin
         // hold every mapped register and the memory at power-on values until the sequence ends; address pointer keeps its value
         wr_d = '0;
         rd_d = '0;
         latch_d = '0;
         full_d = 1'b0;
         lost_d = '0;
         byteIdx_d = '0;
         bufCfg_d = `OSF_BUF_CFG_RESET;
         acqCfg_d = `OSF_ACQ_CFG_RESET;
         psave_d = 1'(`OSF_MODE_RESET >> `OSF_PSAVE_BIT);
         mode_d = 3'(`OSF_MODE_RESET);
         for (int i = 0; i < DEPTH; i++) begin
            mem_d[i][0] = '0;
            mem_d[i][1] = '0;
         end
         if (srstCnt_q == 3'h0) begin
            state_d = osf_pkg::OSF_RUN;
         end else begin
            srstCnt_d = srstCnt_q - 3'h1;
         end
      end
      unread = full_d ? 6'd32 : {1'b0, 5'(wr_d - rd_d)};
      // level while backlog reaches 32 minus the field; forced low in power-save
      afull_d = !psave_d && (unread >= (6'd32 - {2'h0, bufCfg_d[`OSF_AFULL_MSB:`OSF_AFULL_LSB]}));
      // set only by power-on, never by soft reset; set wins over clear
      pwrRdy_d = !psave_d && (!porSeen_q || (pwrRdy_q && !powerReadyClear));
      divCnt_d = divCnt_q + 24'h000001;
      tick_d = 1'b0;
      if (!running) begin
         divCnt_d = '0;
      end else if (divCnt_q >= ratePeriod(acqCfg_q[`OSF_RATE_MSB:`OSF_RATE_LSB]) - 24'h000001) begin
         divCnt_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= osf_pkg::OSF_RUN;
         srstCnt_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i][0] <= '0;
            mem_q[i][1] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         latch_q <= '0;
         full_q <= 1'b0;
         lost_q <= '0;
         byteIdx_q <= '0;
         addr_q <= '0;
         bufCfg_q <= `OSF_BUF_CFG_RESET;
         acqCfg_q <= `OSF_ACQ_CFG_RESET;
         rdData_q <= '0;
         psave_q <= 1'b0;
         mode_q <= '0;
         divCnt_q <= '0;
         tick_q <= 1'b0;
         afull_q <= 1'b0;
         pwrRdy_q <= 1'b0;
         porSeen_q <= 1'b0;
      end else begin
         state_q <= state_d;
         srstCnt_q <= srstCnt_d;
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         latch_q <= latch_d;
         full_q <= full_d;
         lost_q <= lost_d;
         byteIdx_q <= byteIdx_d;
         addr_q <= addr_d;
         bufCfg_q <= bufCfg_d;
         acqCfg_q <= acqCfg_d;
         rdData_q <= rdData_d;
         psave_q <= psave_d;
         mode_q <= mode_d;
         divCnt_q <= divCnt_d;
         tick_q <= tick_d;
         afull_q <= afull_d;
         pwrRdy_q <= pwrRdy_d;
         porSeen_q <= 1'b1;
      end
   end

   assign regRdData = rdData_q;
   assign sampleTick = tick_q;
   assign converterRangeSelect = acqCfg_q[`OSF_RANGE_MSB:`OSF_RANGE_LSB];
   assign sampleRateSelect = acqCfg_q[`OSF_RATE_MSB:`OSF_RATE_LSB];
   assign ledPulseWidthSelect = acqCfg_q[`OSF_PW_MSB:`OSF_PW_LSB];
   assign powerSaveActive = psave_q;
   assign almostFullFlag = afull_q;
   assign powerReadyFlag = pwrRdy_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   logic popNow, pushOk, quietPtr;
   assign popNow = regRdStb && !regAddrLoad && addr_q == `OSF_ADDR_DATA && byteIdx_q == 3'h0
      && !(!full_q && wr_q == rd_q) && state_q == osf_pkg::OSF_RUN;
   assign quietPtr = !(regWrStb && !regAddrLoad && !regRdStb) && state_q == osf_pkg::OSF_RUN;
   assign pushOk = avgValid && running && quietPtr && !regRdStb;

   AST_WR_ADVANCE: assert property (pushOk && !full_q |=> wr_q == $past(wr_q) + 5'h01)
      else $error("write position did not advance on push");
   AST_RD_ADVANCE: assert property (popNow |=> rd_q == $past(rd_q) + 5'h01 && lost_q == 5'h00)
      else $error("read position did not advance on pop");
   AST_FULL_HOLD: assert property (pushOk && full_q && !bufCfg_q[`OSF_WRAP_BIT] |=> $stable(wr_q) && full_q)
      else $error("full buffer accepted a sample without wrap");
   AST_LOST_SAT: assert property (lost_q > `OSF_LOST_MAX |-> $past(regWrStb))
      else $error("lost count passed saturation");
   AST_RATE_CLAMP: assert property (sampleRateSelect <= rateMax(ledPulseWidthSelect))
      else $error("stored rate exceeds pulse width limit");
   AST_PSAVE_FLAGS: assert property (powerSaveActive |-> !almostFullFlag && !powerReadyFlag)
      else $error("flag raised in power-save");
   AST_SRST_SEQ: assert property (state_q == osf_pkg::OSF_SRST && $past(state_q) == osf_pkg::OSF_RUN
      |-> state_q == osf_pkg::OSF_SRST [*4] ##1 state_q == osf_pkg::OSF_RUN && wr_q == 5'h00 && mode_q == 3'h0)
      else $error("soft reset did not complete in four cycles");
   AST_SRST_NO_PWR: assert property (state_q == osf_pkg::OSF_SRST && !pwrRdy_q |=> !powerReadyFlag)
      else $error("soft reset raised power-ready");
   AST_BYTE_ZERO: assert property (regRdStb && !regAddrLoad && addr_q == `OSF_ADDR_DATA
      && (byteIdx_q == 3'h0 || byteIdx_q == 3'h3) |=> regRdData[7:2] == 6'h00)
      else $error("unused high bits of first byte not zero");
   AST_ADDR_HOLD: assert property (regRdStb && !regAddrLoad && addr_q == `OSF_ADDR_DATA |=> addr_q == `OSF_ADDR_DATA)
      else $error("data register read moved the address pointer");

   COV_POP: cover property (popNow ##[1:6] popNow);
   COV_FULL: cover property (full_q && pushOk && bufCfg_q[`OSF_WRAP_BIT]);
   COV_SRST: cover property (state_q == osf_pkg::OSF_SRST ##5 state_q == osf_pkg::OSF_RUN);
endmodule

// ### sim/osf_conv_model.sv
// converter stand-in: delivers one red and IR result per push request
`timescale 1ns/100ps
module osf_conv_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic pushReq,
   input wire logic [17:0] pushRed,
   input wire logic [17:0] pushIr,
   output logic sampleValid,
   output logic [17:0] redSample,
   output logic [17:0] irSample
);
   // between results the data lines toggle so stale values never look valid
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sampleValid <= 1'b0;
         redSample <= 18'h00000;
         irSample <= 18'h00000;
      end else if (pushReq) begin
         sampleValid <= 1'b1;
         redSample <= pushRed;
         irSample <= pushIr;
      end else begin
         sampleValid <= 1'b0;
         redSample <= ~redSample;
         irSample <= ~irSample;
      end
   end
endmodule

// ### sim/osf_ctrl_bench.sv
// self-checking bench of the sample buffer controller
`timescale 1ns/100ps
`include "osf_regs.svh"
module osf_ctrl_bench;
   localparam logic [11:0] RMAX = 12'hBBF;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic regAddrLoad = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic regWrStb = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic regRdStb = 1'b0;
   logic powerReadyClear = 1'b0;
   logic pushReq = 1'b0;
   logic [17:0] pushRed = 18'h00000;
   logic [17:0] pushIr = 18'h00000;
   logic [7:0] regRdData;
   logic sampleValid;
   logic [17:0] redSample;
   logic [17:0] irSample;
   logic [1:0] converterRangeSelect;
   logic [2:0] sampleRateSelect;
   logic [1:0] ledPulseWidthSelect;
   logic powerSaveActive;
   logic almostFullFlag;
   logic powerReadyFlag;
   logic sampleTick;
   logic [7:0] v;
   logic [2:0] avgCodes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
   logic [7:0] exp6 [6] = '{8'h02, 8'hA5, 8'hC3, 8'h01, 8'h5A, 8'h3C};
   int miscompares = 0;
   int numChecks = 0;
   int n;

   always #10 clock = ~clock;

   osf_ctrl #(.CLK_HZ(320000), .RATE_MAX_BY_PW(RMAX)) u_osf_ctrl (.clock(clock), .arst_n(arst_n),
      .regAddrLoad(regAddrLoad), .regAddr(regAddr), .regWrStb(regWrStb), .regWrData(regWrData),
      .regRdStb(regRdStb), .regRdData(regRdData),
      .sampleTick(sampleTick), .sampleValid(sampleValid), .redSample(redSample), .irSample(irSample),
      .converterRangeSelect(converterRangeSelect), .sampleRateSelect(sampleRateSelect),
      .ledPulseWidthSelect(ledPulseWidthSelect), .powerSaveActive(powerSaveActive),
      .almostFullFlag(almostFullFlag), .powerReadyFlag(powerReadyFlag), .powerReadyClear(powerReadyClear));

   osf_conv_model u_osf_conv_model (.clock(clock), .arst_n(arst_n), .pushReq(pushReq), .pushRed(pushRed),
      .pushIr(pushIr), .sampleValid(sampleValid), .redSample(redSample), .irSample(irSample));

   task automatic final_report();
      $display("checks %0d miscompares %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic setAddr(input logic [7:0] a);
      @(posedge clock);
      regAddrLoad <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regAddrLoad <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      setAddr(a);
      regWrStb <= 1'b1;
      regWrData <= d;
      @(posedge clock);
      regWrStb <= 1'b0;
      // let the written value settle before callers look at outputs
      #1;
   endtask

   task automatic rdb(output logic [7:0] d);
      @(posedge clock);
      regRdStb <= 1'b1;
      @(posedge clock);
      regRdStb <= 1'b0;
      @(posedge clock);
      #1 d = regRdData;
   endtask

   task automatic chkReg(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      setAddr(a);
      rdb(d);
      chk(nm, d, e);
   endtask

   task automatic push(input logic [17:0] r, input logic [17:0] i);
      @(posedge clock);
      pushReq <= 1'b1;
      pushRed <= r;
      pushIr <= i;
      @(posedge clock);
      pushReq <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic clearPos();
      wr(`OSF_ADDR_WR_POS, 8'h00);
      wr(`OSF_ADDR_RD_POS, 8'h00);
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      final_report();
   end

   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      chk("powerReady", {7'h00, powerReadyFlag}, 8'h01);
      for (int a = 4; a <= 10; a++) chkReg(8'(a), 8'h00, "resetValue");
      chkReg(8'h20, 8'h00, "unmapped");
      // rate codes unclamped at the shortest pulse, then clamp per pulse width
      for (int r = 0; r < 8; r++) begin
         wr(`OSF_ADDR_ACQ_CFG, {3'h0, 3'(r), 2'h0});
         chk("rate", {5'h00, sampleRateSelect}, 8'(r));
      end
      for (int p = 0; p < 4; p++) begin
         wr(`OSF_ADDR_ACQ_CFG, {1'b0, 2'(p), 3'h7, 2'(p)});
         chk("clampRate", {5'h00, sampleRateSelect}, {5'h00, RMAX[3*p +: 3]});
         chk("range", {6'h00, converterRangeSelect}, 8'(p));
         chk("pulse", {6'h00, ledPulseWidthSelect}, 8'(p));
         chkReg(`OSF_ADDR_ACQ_CFG, {1'b0, 2'(p), RMAX[3*p +: 3], 2'(p)}, "acqCfg");
      end
      wr(`OSF_ADDR_MODE, 8'h03);
      // fastest rate: one tick every 100 cycles at the bench clock rate
      wr(`OSF_ADDR_ACQ_CFG, 8'h1C);
      n = 0;
      while (!sampleTick && n < 200) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (!sampleTick && n < 200);
      chk("tickPeriod", 8'(n), 8'h64);
      wr(`OSF_ADDR_ACQ_CFG, 8'h03);
      foreach (avgCodes[k]) begin
         n = (avgCodes[k] > 3'h5) ? 32 : (1 << avgCodes[k]);
         wr(`OSF_ADDR_BUF_CFG, {avgCodes[k], 5'h00});
         clearPos();
         for (int j = 0; j < n; j++) push(18'(j * 4), 18'(j * 8));
         chkReg(`OSF_ADDR_WR_POS, 8'h01, "avgWrPos");
         setAddr(`OSF_ADDR_DATA);
         for (int b = 0; b < 3; b++) rdb(v);
         chk("avgRed", v, 8'(2 * (n - 1)));
      end
      wr(`OSF_ADDR_BUF_CFG, 8'h00);
      clearPos();
      push(18'h2A5C3, 18'h15A3C);
      push(18'h3FFFF, 18'h00001);
      chkReg(`OSF_ADDR_WR_POS, 8'h02, "wrPos");
      setAddr(`OSF_ADDR_DATA);
      for (int b = 0; b < 6; b++) begin
         rdb(v);
         chk("dataByte", v, exp6[b]);
      end
      chkReg(`OSF_ADDR_RD_POS, 8'h01, "rdPos");
      wr(`OSF_ADDR_RD_POS, 8'h00);
      setAddr(`OSF_ADDR_DATA);
      rdb(v);
      chk("reread", v, 8'h02);
      wr(`OSF_ADDR_MODE, 8'h07);
      chkReg(`OSF_ADDR_ACQ_CFG, 8'h03, "keptCfg");
      setAddr(`OSF_ADDR_DATA);
      rdb(v);
      chk("keptData", v, 8'h03);
      // shortest pulse keeps 15 bits, lower three read zero
      wr(`OSF_ADDR_ACQ_CFG, 8'h00);
      clearPos();
      push(18'h3FFFF, 18'h3FFFF);
      setAddr(`OSF_ADDR_DATA);
      for (int b = 0; b < 3; b++) rdb(v);
      chk("maskedLow", v, 8'hF8);
      // red-only mode: three bytes per sample, fourth read starts the next sample
      wr(`OSF_ADDR_MODE, 8'h02);
      clearPos();
      push(18'h1C000, 18'h3FFFF);
      push(18'h2A5C3, 18'h3FFFF);
      setAddr(`OSF_ADDR_DATA);
      for (int b = 0; b < 4; b++) rdb(v);
      chk("redOnly", v, 8'h02);
      chkReg(`OSF_ADDR_RD_POS, 8'h02, "redOnlyPos");
      wr(`OSF_ADDR_MODE, 8'h03);
      // fill to the almost-full level, then to full and beyond
      wr(`OSF_ADDR_ACQ_CFG, 8'h03);
      wr(`OSF_ADDR_BUF_CFG, 8'h0F);
      clearPos();
      wr(`OSF_ADDR_LOST, 8'h00);
      for (int j = 0; j < 16; j++) push(18'(j), 18'(j));
      chk("belowFull", {7'h00, almostFullFlag}, 8'h00);
      push(18'h00010, 18'h00010);
      chk("almostFull", {7'h00, almostFullFlag}, 8'h01);
      for (int j = 0; j < 15; j++) push(18'(j), 18'(j));
      chkReg(`OSF_ADDR_WR_POS, 8'h00, "fullWrPos");
      push(18'h00001, 18'h00001);
      push(18'h00001, 18'h00001);
      chkReg(`OSF_ADDR_LOST, 8'h02, "lost");
      chkReg(`OSF_ADDR_WR_POS, 8'h00, "heldWrPos");
      setAddr(`OSF_ADDR_DATA);
      rdb(v);
      chkReg(`OSF_ADDR_LOST, 8'h00, "lostCleared");
      wr(`OSF_ADDR_BUF_CFG, 8'h1F);
      push(18'h00002, 18'h00002);
      push(18'h00003, 18'h00003);
      chkReg(`OSF_ADDR_WR_POS, 8'h02, "wrapWrPos");
      chkReg(`OSF_ADDR_RD_POS, 8'h02, "wrapRdPos");
      wr(`OSF_ADDR_MODE, 8'h87);
      chk("psave", {7'h00, powerSaveActive}, 8'h01);
      chk("psaveFlag", {7'h00, almostFullFlag}, 8'h00);
      chk("psaveReady", {7'h00, powerReadyFlag}, 8'h00);
      chkReg(`OSF_ADDR_BUF_CFG, 8'h1F, "psaveKeep");
      wr(`OSF_ADDR_MODE, 8'h07);
      // second power-on reset in mid-run: write position cleared, power-ready raised again
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      chk("readyAgain", {7'h00, powerReadyFlag}, 8'h01);
      chkReg(`OSF_ADDR_WR_POS, 8'h00, "porWrPos");
      @(posedge clock);
      powerReadyClear <= 1'b1;
      @(posedge clock);
      powerReadyClear <= 1'b0;
      @(posedge clock);
      #1 chk("readyCleared", {7'h00, powerReadyFlag}, 8'h00);
      wr(`OSF_ADDR_BUF_CFG, 8'h1F);
      wr(`OSF_ADDR_ACQ_CFG, 8'h63);
      wr(`OSF_ADDR_MODE, 8'h47);
      repeat (10) @(posedge clock);
      for (int a = 4; a <= 10; a++) chkReg(8'(a), 8'h00, "softReset");
      chk("rangeOut", {6'h00, converterRangeSelect}, 8'h00);
      chk("noReadyEvent", {7'h00, powerReadyFlag}, 8'h00);
      final_report();
   end
endmodule
